//--- cpr_lookup.sv
// Purpose: Text and pattern RAM lookup, scan of commons and segment dots
// Assumes: Host, cursor and font ROM signals are on i_clk
// Notes: Font ROM contents live outside; they answer one cycle after o_rom_*
`timescale 1ns/10ps
`default_nettype none
module cpr_lookup
    import cpr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_font_tall,
    input wire logic i_two_lines,
    input wire logic i_host_req,
    input wire logic i_host_sel_pat,
    input wire logic [cpr_pkg::TEXT_AW-1:0] i_host_addr,
    input wire logic [cpr_pkg::DATA_W-1:0] i_host_data,
    input wire logic i_cursor_on,
    input wire logic [cpr_pkg::TEXT_AW-1:0] i_cursor_addr,
    input wire logic [cpr_pkg::CHAR_DOTS-1:0] i_rom_bits,
    output logic o_host_ack,
    output logic [cpr_pkg::DATA_W-1:0] o_rom_code,
    output logic [3:0] o_rom_line,
    output logic [cpr_pkg::NUM_COM-1:0] o_com,
    output logic [cpr_pkg::NUM_SEG-1:0] o_seg
);
    import cpr_pkg::*;

    function automatic logic [CHAR_DOTS-1:0] dots_of(input logic [CHAR_DOTS-1:0] bits);
        logic [CHAR_DOTS-1:0] r;
        r = '0;
        for (int i = 0; i < CHAR_DOTS; i++) begin
            r[i] = bits[CHAR_DOTS-1-i];
        end
        return r;
    endfunction

    cpr_state_t state;
    logic host_slot;
    logic [4:0] col;
    logic [3:0] row;
    logic [TEXT_AW-1:0] text_addr;
    logic use_ram;
    logic [NUM_SEG-1:0] shadow;
    logic [4:0] rows_used;
    logic [3:0] line;
    logic [TEXT_AW-1:0] next_text_addr;
    logic host_wr;
    logic ref_slot;
    logic text_re;
    logic pat_re;
    logic [PAT_AW-1:0] pat_addr;
    logic [DATA_W-1:0] text_q;
    logic [DATA_W-1:0] pat_q;
    logic [CHAR_DOTS-1:0] raw_bits;
    logic [CHAR_DOTS-1:0] next_bits;
    logic cursor_here;

    // Only the active commons are ever selected, the rest stay non-selected
    always_comb begin
        if (i_font_tall) begin
            rows_used = ROWS_TALL;
        end else if (i_two_lines) begin
            rows_used = ROWS_TWO_SHORT;
        end else begin
            rows_used = ROWS_ONE_SHORT;
        end
    end

    always_comb begin
        line = i_font_tall ? row : {1'b0, row[2:0]};
        next_text_addr = {2'b00, col};
        if (!i_font_tall && i_two_lines && row[3]) begin
            next_text_addr = LINE2_BASE | {2'b00, col};
        end
    end

    // Host owns odd cycles, refresh owns even ones, so writes never tear a scan
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            host_slot <= 1'b0;
        end else begin
            host_slot <= ~host_slot;
        end
    end

    assign ref_slot = ~host_slot;
    assign host_wr = host_slot & i_host_req & ~o_host_ack;
    assign text_re = ref_slot & (state == ST_TEXT);
    assign pat_re = ref_slot & (state == ST_PAT);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_host_ack <= 1'b0;
        end else begin
            o_host_ack <= host_wr;
        end
    end

    // Pattern address: code bits 2:1 pick the pattern, 3 and 0 are dropped
    always_comb begin
        if (host_slot) begin
            pat_addr = i_host_addr[PAT_AW-1:0];
        end else begin
            pat_addr = {text_q[2:1], line};
        end
    end

    cpr_mem #(
        .AW(TEXT_AW),
        .DW(DATA_W)
    ) u_text_ram (
        .i_clk(i_clk),
        .i_we(host_wr & ~i_host_sel_pat),
        .i_re(text_re),
        .i_addr(host_slot ? i_host_addr : next_text_addr),
        .i_wdata(i_host_data),
        .o_rdata(text_q)
    );

    cpr_mem #(
        .AW(PAT_AW),
        .DW(DATA_W)
    ) u_pattern_ram (
        .i_clk(i_clk),
        .i_we(host_wr & i_host_sel_pat),
        .i_re(pat_re),
        .i_addr(pat_addr),
        .i_wdata(i_host_data),
        .o_rdata(pat_q)
    );

    // Bits 7:5 of the pattern byte never reach a dot
    assign raw_bits = use_ram ? pat_q[CHAR_DOTS-1:0] : i_rom_bits;
    assign cursor_here = i_cursor_on & (i_cursor_addr == text_addr);

    // Stored cursor-line ones show even with no cursor here; host must keep them zero
    always_comb begin
        next_bits = raw_bits;
        if (i_font_tall && line == CURSOR_LINE) begin
            next_bits = raw_bits | {CHAR_DOTS{cursor_here}};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= ST_TEXT;
        end else if (ref_slot) begin
            unique case (state)
                ST_TEXT: begin
                    state <= ST_PAT;
                end
                ST_PAT: begin
                    state <= ST_DOTS;
                end
                ST_DOTS: begin
                    state <= ST_TEXT;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            text_addr <= '0;
            use_ram <= 1'b0;
            o_rom_code <= '0;
            o_rom_line <= '0;
        end else if (ref_slot && state == ST_TEXT) begin
            text_addr <= next_text_addr;
        end else if (ref_slot && state == ST_PAT) begin
            use_ram <= (text_q[7:4] == PAT_PAGE_CODE);
            o_rom_code <= text_q;
            o_rom_line <= line;
        end
    end

    // Column and row walk; a whole row is shown at once when it is complete
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            col <= '0;
            row <= '0;
            shadow <= '0;
            o_seg <= '0;
            o_com <= '0;
        end else if (ref_slot && state == ST_DOTS) begin
            shadow[int'(col) * CHAR_DOTS +: CHAR_DOTS] <= dots_of(next_bits);
            if (col == LAST_COL) begin
                col <= '0;
                o_seg <= shadow;
                o_seg[int'(col) * CHAR_DOTS +: CHAR_DOTS] <= dots_of(next_bits);
                o_com <= '0;
                o_com[row] <= 1'b1;
                if ({1'b0, row} == rows_used - 5'h01) begin
                    row <= '0;
                end else begin
                    row <= row + 4'h1;
                end
            end else begin
                col <= col + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- cpr_pkg.sv
// Purpose: Constants for the character pattern lookup and dot refresh path
// Assumes: 5x10 user patterns, 20 characters of 5 dots on 100 segments
// Notes: Operation list follows
// Operation
// - Pattern data bits 0..4 form five dot columns, bit 4 leftmost.
// - Character code bits 1 and 2 become pattern address bits 4 and 5.
// - A pattern bit of one lights its dot, zero leaves it dark.
// - Pattern address bits 0..3 select the line within the pattern.
// - Eleventh line is the cursor line, shown as pattern OR cursor.
// - Any one in the eleventh line lights regardless of cursor position.
// - Codes with bits 4..7 all zero fetch from user pattern RAM.
// - Code bits 0 and 3 are ignored for pattern RAM codes.
// - Host writes and refresh reads use separate time slots.
// - Sixteen common scan outputs and one hundred segment outputs.
// - Selected commons scan; remaining commons stay at non-selection.
`default_nettype none
package cpr_pkg;
    localparam int NUM_COM = 16;
    localparam int NUM_SEG = 100;
    localparam int NUM_CHARS = 20;
    localparam int CHAR_DOTS = 5;
    localparam int PAT_AW = 6;
    localparam int TEXT_AW = 7;
    localparam int DATA_W = 8;
    localparam logic [3:0] CURSOR_LINE = 4'hA;
    localparam logic [4:0] ROWS_TALL = 5'h0B;
    localparam logic [4:0] ROWS_TWO_SHORT = 5'h10;
    localparam logic [4:0] ROWS_ONE_SHORT = 5'h08;
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [4:0] LAST_COL = 5'h13;
    localparam logic [3:0] PAT_PAGE_CODE = 4'h0;
    typedef enum logic [2:0] {
        ST_TEXT = 3'b001,
        ST_PAT = 3'b010,
        ST_DOTS = 3'b100
    } cpr_state_t;
endpackage
`default_nettype wire

//--- cpr_mem.sv
// Purpose: Single-port RAM with registered read data
// Assumes: One access per cycle, write has priority over read
// Notes: Read data holds until the next read
`timescale 1ns/10ps
`default_nettype none
module cpr_mem #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end else if (i_re) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule
`default_nettype wire

//--- cpr_lookup_sva.sv
// Purpose: Port checks of the lookup block
// Assumes: Text and pattern bus set as in tall mode
// Notes: Bound to every instance
`timescale 1ns/10ps
`default_nettype none
module cpr_lookup_chk (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_font_tall,
    input wire logic i_host_req,
    input wire logic o_host_ack,
    input wire logic [15:0] o_com,
    input wire logic [99:0] o_seg
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    com_onehot_a: assert property ($onehot0(o_com)) else $error("two commons");
    com_unused_a: assert property (i_font_tall |-> o_com[15:11] == 5'h00) else $error("spare com");
    com_wrap_a: assert property (i_font_tall && $fell(o_com[10]) |-> o_com[0]) else $error("wrap");
    row_hold_a: assert property ($changed(o_com) |=> $stable(o_com) [*8]) else $error("row");
    seg_sync_a: assert property ($changed(o_seg) |-> $changed(o_com)) else $error("seg");
    ack_pulse_a: assert property (o_host_ack |=> !o_host_ack) else $error("ack long");
    ack_time_a: assert property ($rose(i_host_req) |-> ##[1:3] o_host_ack) else $error("ack late");
    reset_quiet_a: assert property (disable iff (1'b0) !i_resetn |=> o_com == 16'h0000
        && o_seg == 100'h0 && !o_host_ack) else $error("reset");
endmodule
bind cpr_lookup cpr_lookup_chk chk_u (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_font_tall(i_font_tall),
    .i_host_req(i_host_req),
    .o_host_ack(o_host_ack),
    .o_com(o_com),
    .o_seg(o_seg)
);
`default_nettype wire

//--- cpr_host_model.sv
// Purpose: Host that writes text and pattern RAM
// Assumes: Request held until ack, or dropped after 8 cycles without one
// Notes: Released bus shows inverted data
`timescale 1ns/10ps
`default_nettype none
module cpr_host_model (
    input wire logic i_clk,
    input wire logic i_ack,
    output logic o_req = 1'b0,
    output logic o_sel_pat = 1'b0,
    output logic [6:0] o_addr = 7'h00,
    output logic [7:0] o_data = 8'h00
);
    task automatic wr(input logic p, input logic [6:0] a, input logic [7:0] d, input logic bad);
        int n = 0;
        @(posedge i_clk);
        #1;
        o_sel_pat = p;
        o_addr = a;
        o_data = (p && a[3:0] == 4'hA && !bad) ? {d[7:5], 5'h00} : d;
        o_req = 1'b1;
        while (i_ack !== 1'b1 && n < 8) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        o_req = 1'b0;
        o_addr = ~a;
        o_data = ~d;
    endtask
endmodule
`default_nettype wire

//--- cpr_lookup_tb.sv
// Purpose: Self-checking bench of the lookup block
// Assumes: Tall font, ROM stand-in answers at once
// Notes: Two-line mode left untested to save time
`timescale 1ns/10ps
`default_nettype none
module cpr_lookup_tb;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic cur_on = 1'b1;
    logic req, sel, ack;
    logic [6:0] addr;
    logic [7:0] data, code;
    logic [3:0] line;
    logic [15:0] com;
    logic [99:0] seg;
    int num_errors = 0;
    int comparisons = 0;
    always #12.5 i_clk = ~i_clk;
    cpr_host_model host_u (.i_clk(i_clk), .i_ack(ack), .o_req(req), .o_sel_pat(sel),
        .o_addr(addr), .o_data(data));
    cpr_lookup dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_font_tall(1'b1),
        .i_two_lines(1'b0), .i_host_req(req), .i_host_sel_pat(sel), .i_host_addr(addr),
        .i_host_data(data), .i_cursor_on(cur_on), .i_cursor_addr(7'h01),
        .i_rom_bits((code == 8'h20 && line != 4'hA) ? 5'h18 : 5'h07), .o_host_ack(ack),
        .o_rom_code(code),
        .o_rom_line(line), .o_com(com), .o_seg(seg));
    task automatic check(input logic [99:0] seen, input logic [99:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask
    task automatic see_row(input int r, input logic [4:0] c1, input logic [4:0] c2);
        int n = 0;
        while (com !== 16'h0001 << r && n < 3000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        // ROM stand-in answers differently only on line 10, so only a line 10 mix-up to the font ROM shows up here
        check(seg, {{17{r == 10 ? 5'h1C : 5'h03}}, c2, c1, r == 0 ? 5'h19 : 5'h00});
    endtask
    task automatic t_load;
        host_u.wr(1'b1, 7'h10, 8'hF3, 1'b0);
        host_u.wr(1'b1, 7'h1A, 8'hFF, 1'b0);
        host_u.wr(1'b1, 7'h1B, 8'hFF, 1'b0); // Twelfth line must stay unseen
        host_u.wr(1'b1, 7'h20, 8'h0C, 1'b0);
        host_u.wr(1'b1, 7'h2A, 8'h04, 1'b1);
        host_u.wr(1'b0, 7'h00, 8'h0B, 1'b0);
        host_u.wr(1'b0, 7'h01, 8'h02, 1'b0);
        host_u.wr(1'b0, 7'h02, 8'h04, 1'b0);
        for (int i = 3; i < 20; i++)
            host_u.wr(1'b0, 7'(i), 8'h20, 1'b0);
    endtask
    task automatic t_rows;
        repeat (1400) @(posedge i_clk);
        see_row(0, 5'h19, 5'h06);
        see_row(10, 5'h1F, 5'h04);
        for (int i = 0; i < 6; i++)
            host_u.wr(1'b0, 7'h03, 8'h20, 1'b0);
        cur_on = 1'b0;
        repeat (1400) @(posedge i_clk);
        see_row(10, 5'h00, 5'h04);
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        #1;
        check(seg, 100'h0);
        check({ack, com, code, line}, 100'h0);
        i_resetn = 1'b1;
        t_load();
        t_rows();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
